// ### rtl/io_option_map.svh
`ifndef IO_OPTION_MAP_SVH
`define IO_OPTION_MAP_SVH
`define OFS_ANALOG_IN0    5'h00
`define OFS_CONV_START    5'h00
`define OFS_ANALOG_IN1    5'h02
`define OFS_ANALOG_IN2    5'h04
`define OFS_ANALOG_IN3    5'h06
`define OFS_ANALOG_OUT0   5'h08
`define OFS_ANALOG_OUT1   5'h0a
`define OFS_INIT_CONFIG   5'h0c
`define OFS_DISCRETE_IN   5'h0f
`define OFS_DISCRETE_OUT  5'h10
`define WORD_OFS_DIN      5'h0e
`define BIT_ROUTE_LO      8
`define BIT_ROUTE_HI      9
`define BIT_EN_PRIMARY    10
`define BIT_EN_SECONDARY  11
`define BIT_CONV_MODE     14
`define INIT_CONFIG_RST   16'h0000
`define CONV_TIME_NS      34000
`define CLK_PERIOD_NS     4
`define CONV_CYCLES       (`CONV_TIME_NS / `CLK_PERIOD_NS)
`endif

// ### rtl/io_option_pkg.sv
package io_option_pkg;
  typedef enum logic [1:0] {CONV_IDLE, CONV_START, CONV_BUSY} conv_state_t;
  typedef logic [11:0] sample_t;
endpackage : io_option_pkg

// ### rtl/conv_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_option_map.svh"
module conv_sequencer
  import io_option_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_start,
  input  wire logic i_adc_done,
  output logic      o_adc_start,
  output logic      o_busy,
  output logic      o_capture
);
  conv_state_t   state_r;
  conv_state_t   state_nxt;
  logic [15:0]   cnt_r;
  logic [15:0]   cnt_nxt;
  localparam logic [15:0] CONV_CYC = 16'(`CONV_CYCLES);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    o_capture = 1'b0;
    case (state_r)
      CONV_IDLE: begin
        if (i_start) begin
          state_nxt = CONV_START;
        end
      end
      CONV_START: begin
        state_nxt = CONV_BUSY;
        cnt_nxt   = 16'h0000;
      end
      CONV_BUSY: begin
        cnt_nxt = cnt_r + 16'h0001;
        // Converter done or timeout, whichever first
        if (i_adc_done || cnt_r >= CONV_CYC) begin
          o_capture = 1'b1;
          state_nxt = CONV_IDLE;
        end
      end
      default: state_nxt = CONV_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= CONV_IDLE;
      cnt_r   <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign o_adc_start = (state_r == CONV_START);
  assign o_busy      = (state_r != CONV_IDLE);
endmodule : conv_sequencer
`default_nettype wire

// ### rtl/io_option_register_map.sv
// How it works
// - Only whole 16-bit words are accepted; byte strobes other than both are ignored.
// - Each analog input reads as a sign-extended 12-bit two's complement value.
// - Each analog output takes the low 12 bits of the written word as a signed reference.
// - Digital input k shows on bit k of the discrete input byte.
// - Bit k of the discrete output byte drives digital output k.
// - In write-start mode any write to the start location while idle starts conversion.
// - One start pulse converts all four inputs at once.
// - Init register resets to 0x0000 at power-up and can be rewritten by the host.
// - End of conversion is the interrupt source event.
// - Bit 9 and the slot route the event (bit 8 is unused); bit 9 set swaps the two requests.
// - Bits 10 and 11 enable the requests; only enabled ones assert.
// - Write-side locations do not read back their written values.
// - Read and write maps share one set of offsets; the address decode does not depend on the slot.
// - Bit 14 selects cyclic trigger (0) or write start (1).
// - In cyclic mode each option trigger pulse while idle starts a conversion.
`timescale 1ns/1ps
`default_nettype none
`include "io_option_map.svh"
module io_option_register_map
  import io_option_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RESETN,
  input  wire logic        I_SLOT_TWO,
  input  wire logic        I_SEL,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic [1:0]  I_BE,
  input  wire logic [4:0]  I_ADDR,
  input  wire logic [15:0] I_WDATA,
  output logic      [15:0] O_RDATA,
  input  wire logic        I_OPT_TRIGGER,
  output logic             O_ADC_START,
  input  wire logic        I_ADC_DONE,
  input  wire logic [11:0] I_ADC_CH0,
  input  wire logic [11:0] I_ADC_CH1,
  input  wire logic [11:0] I_ADC_CH2,
  input  wire logic [11:0] I_ADC_CH3,
  input  wire logic [7:0]  I_DISCRETE_IN,
  output logic      [7:0]  O_DISCRETE_OUT,
  output logic      [11:0] O_ANALOG_OUT0,
  output logic      [11:0] O_ANALOG_OUT1,
  output logic             O_INTERRUPT_REQUEST_ONE,
  output logic             O_INTERRUPT_REQUEST_TWO
);
  function automatic logic [15:0] sext12(input sample_t v);
    sext12 = {{4{v[11]}}, v};
  endfunction : sext12

  logic        full_wr;
  logic        full_rd;
  logic        start_req;
  logic        capture;
  logic        adc_start;
  logic        busy;
  logic        eoc_event;
  logic        req_primary;
  logic        req_secondary;
  sample_t     ain_r   [4];
  sample_t     ain_nxt [4];
  sample_t     aout0_r, aout0_nxt, aout1_r, aout1_nxt;
  logic [7:0]  dout_r, dout_nxt;
  logic [15:0] init_r, init_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        eoc_r, eoc_nxt;
  logic        interrupt_request_one_r, interrupt_request_one_nxt, interrupt_request_two_r, interrupt_request_two_nxt;

  assign full_wr = I_SEL && I_WR && (I_BE == 2'b11);
  assign full_rd = I_SEL && I_RD && (I_BE == 2'b11);

  always_comb begin
    if (init_r[`BIT_CONV_MODE]) begin
      start_req = full_wr && (I_ADDR == `OFS_CONV_START);
    end else begin
      start_req = I_OPT_TRIGGER;
    end
  end

  conv_sequencer u_seq (
    .i_clk       (I_CLK),
    .i_resetn    (I_RESETN),
    .i_start     (start_req),
    .i_adc_done  (I_ADC_DONE),
    .o_adc_start (adc_start),
    .o_busy      (busy),
    .o_capture   (capture)
  );
  assign O_ADC_START = adc_start;

  always_comb begin
    aout0_nxt = aout0_r;
    aout1_nxt = aout1_r;
    dout_nxt  = dout_r;
    init_nxt  = init_r;
    for (int i = 0; i < 4; i++) begin
      ain_nxt[i] = ain_r[i];
    end
    if (capture) begin
      ain_nxt[0] = I_ADC_CH0;
      ain_nxt[1] = I_ADC_CH1;
      ain_nxt[2] = I_ADC_CH2;
      ain_nxt[3] = I_ADC_CH3;
    end
    if (full_wr) begin
      case (I_ADDR)
        `OFS_ANALOG_OUT0: aout0_nxt = I_WDATA[11:0];
        `OFS_ANALOG_OUT1: aout1_nxt = I_WDATA[11:0];
        `OFS_INIT_CONFIG: init_nxt = I_WDATA;
        `OFS_DISCRETE_OUT: dout_nxt = I_WDATA[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (full_rd) begin
      case (I_ADDR)
        `OFS_ANALOG_IN0: rdata_nxt = sext12(ain_r[0]);
        `OFS_ANALOG_IN1: rdata_nxt = sext12(ain_r[1]);
        `OFS_ANALOG_IN2: rdata_nxt = sext12(ain_r[2]);
        `OFS_ANALOG_IN3: rdata_nxt = sext12(ain_r[3]);
        // byte at high half of word 0xe
        `WORD_OFS_DIN: rdata_nxt = {I_DISCRETE_IN, 8'h00};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  assign eoc_event = capture;
  // routing, swapped on slot two or bit 9 but not both
  always_comb begin
    logic swap;
    logic gate;
    swap = init_r[`BIT_ROUTE_HI] ^ I_SLOT_TWO;
    // Bit 10 gates when bit 9 is clear, bit 11 when bit 9 is set, on either slot
    gate = init_r[`BIT_ROUTE_HI] ? init_r[`BIT_EN_SECONDARY]
                                 : init_r[`BIT_EN_PRIMARY];
    eoc_nxt = eoc_event;
    req_primary   = eoc_r && !swap;
    req_secondary = eoc_r && swap;
    interrupt_request_one_nxt = req_primary && gate;
    interrupt_request_two_nxt = req_secondary && gate;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      for (int i = 0; i < 4; i++) begin
        ain_r[i] <= 12'h000;
      end
      aout0_r <= 12'h000;
      aout1_r <= 12'h000;
      dout_r  <= 8'h00;
      init_r  <= `INIT_CONFIG_RST;
      rdata_r <= 16'h0000;
      eoc_r   <= 1'b0;
      interrupt_request_one_r  <= 1'b0;
      interrupt_request_two_r  <= 1'b0;
    end else begin
      ain_r   <= ain_nxt;
      aout0_r <= aout0_nxt;
      aout1_r <= aout1_nxt;
      dout_r  <= dout_nxt;
      init_r  <= init_nxt;
      rdata_r <= rdata_nxt;
      eoc_r   <= eoc_nxt;
      interrupt_request_one_r  <= interrupt_request_one_nxt;
      interrupt_request_two_r  <= interrupt_request_two_nxt;
    end
  end

  assign O_RDATA                 = rdata_r;
  assign O_DISCRETE_OUT          = dout_r;
  assign O_ANALOG_OUT0           = aout0_r;
  assign O_ANALOG_OUT1           = aout1_r;
  assign O_INTERRUPT_REQUEST_ONE = interrupt_request_one_r;
  assign O_INTERRUPT_REQUEST_TWO = interrupt_request_two_r;
endmodule : io_option_register_map
`default_nettype wire

// ### verification/io_option_properties.sv
`timescale 1ns/1ps
`default_nettype none
module io_option_properties (
  input wire logic        I_CLK,
  input wire logic        I_RESETN,
  input wire logic        I_SLOT_TWO,
  input wire logic        I_SEL,
  input wire logic        I_WR,
  input wire logic        I_RD,
  input wire logic [1:0]  I_BE,
  input wire logic [4:0]  I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic [15:0] O_RDATA,
  input wire logic        I_OPT_TRIGGER,
  input wire logic        O_ADC_START,
  input wire logic        I_ADC_DONE,
  input wire logic [7:0]  O_DISCRETE_OUT,
  input wire logic        O_INTERRUPT_REQUEST_ONE,
  input wire logic        O_INTERRUPT_REQUEST_TWO
);
  logic [15:0] cfg_r;
  logic [15:0] cfg_nxt;
  logic        wr;
  logic        rd;
  logic        swp;
  logic        en;
  logic        go;
  logic [1:0]  irq;
  assign wr  = I_SEL && I_WR && I_BE == 2'h3;
  assign rd  = I_SEL && I_RD && I_BE == 2'h3;
  assign swp = cfg_r[9] ^ I_SLOT_TWO;
  assign en  = cfg_r[9] ? cfg_r[11] : cfg_r[10];
  assign go  = cfg_r[14] ? wr && I_ADDR == 5'h00 : I_OPT_TRIGGER;
  assign irq = {O_INTERRUPT_REQUEST_TWO, O_INTERRUPT_REQUEST_ONE};
  // Shadow of the init register, same reset value as the design
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr && I_ADDR == 5'h0c) cfg_nxt = I_WDATA;
  end
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) cfg_r <= 16'h0000;
    else cfg_r <= cfg_nxt;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  sequence eoc_s;
    I_ADC_DONE && en;
  endsequence
  AST_START_CAUSE: assert property (O_ADC_START |-> $past(go))
    else $error("start without cause");
  AST_START_ONE: assert property (O_ADC_START |=> !O_ADC_START)
    else $error("start too long");
  AST_IRQ_ONE: assert property (irq[0] |-> !swp && en)
    else $error("request one misrouted");
  AST_IRQ_TWO: assert property (irq[1] |-> swp && en)
    else $error("request two misrouted");
  AST_EOC: assert property (eoc_s |-> ##2 irq != 2'h0)
    else $error("no request after done");
  AST_IRQ_CAUSE: assert property (irq != 2'h0 |-> $past(I_ADC_DONE, 2))
    else $error("request without done");
  AST_RD_WO: assert property (rd && I_ADDR == 5'h08 |=> O_RDATA == 16'h0)
    else $error("write side read back");
  AST_DOUT: assert property (wr && I_ADDR == 5'h10 |=>
    O_DISCRETE_OUT == $past(I_WDATA[7:0])) else $error("output byte");
endmodule : io_option_properties
bind io_option_register_map io_option_properties chk_u (.*);
`default_nettype wire

// ### verification/adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [15:0] dly,
  output logic             done,
  output logic [3:0][11:0] ch
);
  logic [11:0] smp [4] = '{12'h7ff, 12'h800, 12'h000, 12'h5a3};
  int          k = 0;
  initial begin
    done = 1'b0;
    ch = '0;
  end
  // Starts while busy are dropped, as a real converter would
  always @(posedge clk) begin
    if (start === 1'b1) begin
      repeat (dly) @(posedge clk);
      for (int i = 0; i < 4; i++) ch[i] <= smp[(k + i) % 4];
      done <= 1'b1;
      k++;
      @(posedge clk);
      done <= 1'b0;
      // Results are inverted after the strobe so late capture shows
      ch <= ~ch;
    end
  end
endmodule : adc_model
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import io_option_pkg::*;
;
  logic        I_CLK = 1'b0, I_RESETN = 1'b0, I_SLOT_TWO = 1'b0;
  logic        I_SEL = 1'b0, I_WR = 1'b0, I_RD = 1'b0;
  logic        I_OPT_TRIGGER = 1'b0, O_ADC_START, I_ADC_DONE;
  logic        O_INTERRUPT_REQUEST_ONE, O_INTERRUPT_REQUEST_TWO;
  logic [1:0]  I_BE = 2'h3;
  logic [4:0]  I_ADDR = 5'h00;
  logic [15:0] I_WDATA = 16'h0, O_RDATA, dly = 16'h1;
  logic [7:0]  I_DISCRETE_IN = 8'h96, O_DISCRETE_OUT;
  logic [11:0] O_ANALOG_OUT0, O_ANALOG_OUT1;
  logic [3:0][11:0] ch;
  sample_t     smp [4] = '{12'h7ff, 12'h800, 12'h000, 12'h5a3};
  logic [18:0] cs [6] = '{19'h24400, 19'h04600, 19'h44a00,
                          19'h54400, 19'h34e00, 19'h14800};
  int          error_cnt = 0, checked = 0, k = 0, nst = 0, n0;
  io_option_register_map dut_u (.*, .I_ADC_CH0(ch[0]), .I_ADC_CH1(ch[1]),
    .I_ADC_CH2(ch[2]), .I_ADC_CH3(ch[3]));
  adc_model adc_u (.clk(I_CLK), .start(O_ADC_START), .dly(dly),
    .done(I_ADC_DONE), .ch(ch));
  initial forever #2 I_CLK = ~I_CLK;
  always @(posedge I_CLK) if (O_ADC_START === 1'b1) nst++;
  task automatic summarize();
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [15:0] e, s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [15:0] d, input logic [1:0] b);
    @(posedge I_CLK);
    I_SEL <= 1'b1;
    I_WR <= w;
    I_RD <= !w;
    I_ADDR <= a;
    I_WDATA <= d;
    I_BE <= b;
    @(posedge I_CLK);
    I_SEL <= 1'b0;
    #1;
  endtask : acc
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0, 2'h3);
    chk("rdata", e, O_RDATA);
  endtask : rdc
  task automatic conv(input logic [1:0] e);
    logic [1:0] q;
    sample_t    v;
    int         i;
    q = 2'h0;
    for (i = 0; i < 200 && I_ADC_DONE !== 1'b1; i++) begin
      @(posedge I_CLK);
      #1;
    end
    if (i == 200) begin
      error_cnt++;
      $display("ERROR done exp 1 got 0");
      summarize();
    end
    repeat (3) begin
      @(posedge I_CLK);
      #1;
      q |= {O_INTERRUPT_REQUEST_TWO, O_INTERRUPT_REQUEST_ONE};
    end
    chk("irq", {14'h0, e}, {14'h0, q});
    for (int j = 0; j < 4; j++) begin
      v = smp[(k + j) % 4];
      rdc(5'(2 * j), {{4{v[11]}}, v});
    end
    k++;
  endtask : conv
  initial begin
    repeat (8) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    rdc(5'h08, 16'h0);
    rdc(5'h0c, 16'h0);
    rdc(5'h12, 16'h0);
    acc(1'b1, 5'h08, 16'h07ff, 2'h3);
    acc(1'b1, 5'h0a, 16'hf800, 2'h3);
    acc(1'b1, 5'h08, 16'h0000, 2'h1);
    chk("aout0", 16'h07ff, 16'(O_ANALOG_OUT0));
    chk("aout1", 16'h0800, 16'(O_ANALOG_OUT1));
    acc(1'b0, 5'h0e, 16'h0, 2'h3);
    chk("din", 16'h0096, 16'(O_RDATA[15:8]));
    acc(1'b1, 5'h10, 16'h00a5, 2'h3);
    chk("dout", 16'h00a5, 16'(O_DISCRETE_OUT));
    for (int t = 0; t < 6; t++) begin
      @(posedge I_CLK);
      I_SLOT_TWO <= cs[t][16];
      dly <= t[0] ? 16'h003c : 16'h0001;
      acc(1'b1, 5'h0c, cs[t][15:0], 2'h3);
      acc(1'b1, 5'h00, cs[t][15:0] ^ 16'h3c5a, 2'h3);
      conv(cs[t][18:17]);
    end
    @(posedge I_CLK);
    I_SLOT_TWO <= 1'b0;
    acc(1'b1, 5'h0c, 16'h0400, 2'h3);
    n0 = nst;
    acc(1'b1, 5'h00, 16'h0000, 2'h3);
    repeat (4) @(posedge I_CLK);
    chk("starts", 16'(n0), 16'(nst));
    I_OPT_TRIGGER <= 1'b1;
    @(posedge I_CLK);
    I_OPT_TRIGGER <= 1'b0;
    conv(2'h1);
    acc(1'b1, 5'h10, 16'h0000, 2'h3);
    chk("dout", 16'h0000, 16'(O_DISCRETE_OUT));
    summarize();
  end
endmodule : tb_top
`default_nettype wire
